// *** rtl/fsic_consts.svh ***
`ifndef FSIC_CONSTS_SVH
`define FSIC_CONSTS_SVH
// Notes on behaviour
// - Identifier-read command switches reads to identification space until another command.
// - Latched status holds until output enable rises or deselect; host toggles between polls.
// - Clear-status opcode 50H, honoured only while idle or suspended.
// - Block erase is setup then confirm, both inside target block; block becomes FFH.
// - After erase host checks erase error and clears status before recovery; host only latches the error, clearing is a separate command.

// Software register byte offsets
`define FSIC_REG_CMD      8'h00
`define FSIC_REG_ADDR     8'h04
`define FSIC_REG_STAT     8'h08
`define FSIC_REG_DATA     8'h0c

// Flash commands and identifier offsets
`define FSIC_CLR_STATUS   8'h50
`define FSIC_ID_MAKER     24'h000000
`define FSIC_ID_DEVICE    24'h000001
`define FSIC_ID_LOCK      24'h000002
`define FSIC_ID_MASTER    24'h000003

// Status register bit positions
`define FSIC_SR_READY     7
`define FSIC_SR_ERASE_ERR 5
`define FSIC_SR_PROG_ERR  4
`define FSIC_SR_LOCKOUT   3
`define FSIC_SR_LOCKVIOL  1

// Host status register layout
`define FSIC_ST_BUSY      0
`define FSIC_ST_REFUSED   1
`define FSIC_ST_EFAIL     2
`define FSIC_ST_RB        3

// Timing
`define FSIC_CLK_NS       4
`define FSIC_T_WP_NS      70
`define FSIC_T_ACC_NS     150
`define FSIC_SYNC_CYC     2
`define FSIC_WP_CYC       ((`FSIC_T_WP_NS + `FSIC_CLK_NS - 1) / `FSIC_CLK_NS)
`define FSIC_RD_CYC       ((`FSIC_T_ACC_NS + `FSIC_CLK_NS - 1) / `FSIC_CLK_NS + `FSIC_SYNC_CYC)
`endif

// *** rtl/fsic_pkg.sv ***
package fsic_pkg;

  typedef enum logic [2:0] {
    FSIC_IDLE     = 3'b000,
    FSIC_NEXT     = 3'b001,
    FSIC_WR_SETUP = 3'b010,
    FSIC_WR_PULSE = 3'b011,
    FSIC_WR_HOLD  = 3'b100,
    FSIC_RD_WAIT  = 3'b101,
    FSIC_GAP      = 3'b110
  } fsic_state_type;

  typedef enum logic [1:0] {
    FSIC_OP_ID    = 2'b00,
    FSIC_OP_STAT  = 2'b01,
    FSIC_OP_CLR   = 2'b10,
    FSIC_OP_ERASE = 2'b11
  } fsic_op_type;

  typedef struct packed {
    logic [23:0] addr;
    logic [15:0] dq_out;
    logic        dq_oe;
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
  } fsic_pins_type;

  typedef struct packed {
    fsic_state_type state;
    fsic_op_type    op;
    logic [1:0]     step;
    logic [7:0]     cnt;
    fsic_pins_type  pins;
    logic [15:0]    dq_s1;
    logic [15:0]    dq_s2;
    logic           rb_s1;
    logic           rb_s2;
    logic [23:0]    addr_reg;
    logic [15:0]    data_reg;
    logic           busy;
    logic           refused;
    logic           efail;
    logic [31:0]    rdata;
  } fsic_regs_type;

endpackage

// *** rtl/fsic_host.sv ***
`include "fsic_consts.svh"

module fsic_host #(
  parameter logic [7:0] OPC_READ_ID = 8'h01,
  parameter logic [7:0] OPC_STATUS  = 8'h02,
  parameter logic [7:0] OPC_SETUP   = 8'h03,
  parameter logic [7:0] OPC_CONFIRM = 8'h04
) (
  input  wire logic        clock_i,
  input  wire logic        rst_b_i,
  input  wire logic [7:0]  sw_addr_i,
  input  wire logic [31:0] sw_wdata_i,
  input  wire logic        sw_wr_i,
  input  wire logic        sw_rd_i,
  output logic      [31:0] sw_rdata_o,
  output logic      [23:0] flash_addr_o,
  input  wire logic [15:0] flash_dq_i,
  output logic      [15:0] flash_dq_o,
  output logic             flash_dq_oe_o,
  output logic             chip_enable_0_n_o,
  output logic             output_enable_n_o,
  output logic             write_enable_n_o,
  input  wire logic        ready_busy_level_i
);

  localparam logic [7:0] WP_CYC = 8'(`FSIC_WP_CYC);
  localparam logic [7:0] RD_CYC = 8'(`FSIC_RD_CYC);

  localparam fsic_pkg::fsic_regs_type RST_VAL = '{
    state: fsic_pkg::FSIC_IDLE,
    op:    fsic_pkg::FSIC_OP_ID,
    pins:  '{addr: '0, dq_out: '0, dq_oe: 1'b0, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1},
    default: '0
  };

  fsic_pkg::fsic_regs_type r_reg;
  fsic_pkg::fsic_regs_type r_next;

  always_comb
  begin
    r_next = r_reg;
    r_next.dq_s1 = flash_dq_i;
    r_next.dq_s2 = r_reg.dq_s1;
    r_next.rb_s1 = ready_busy_level_i;
    r_next.rb_s2 = r_reg.rb_s1;

    r_next.rdata = '0;
    if (sw_rd_i)
    begin
      case (sw_addr_i)
        `FSIC_REG_ADDR: r_next.rdata = {8'h00, r_reg.addr_reg};
        `FSIC_REG_STAT:
        begin
          r_next.rdata[`FSIC_ST_BUSY]    = r_reg.busy;
          r_next.rdata[`FSIC_ST_REFUSED] = r_reg.refused;
          r_next.rdata[`FSIC_ST_EFAIL]   = r_reg.efail;
          r_next.rdata[`FSIC_ST_RB]      = r_reg.rb_s2;
          r_next.rdata[1:0]              = {r_reg.rdata[1], r_next.rdata[`FSIC_ST_BUSY]};
          r_next.rdata[9:8]              = r_reg.op;
        end
        `FSIC_REG_DATA: r_next.rdata = {16'h0000, r_reg.data_reg};
        default:        r_next.rdata = '0;
      endcase
    end
    if (sw_rd_i && sw_addr_i == `FSIC_REG_STAT)
    begin
      r_next.rdata[1] = r_reg.refused;
    end

    if (sw_wr_i && sw_addr_i == `FSIC_REG_ADDR && !r_reg.busy)
    begin
      r_next.addr_reg = sw_wdata_i[23:0];
    end

    case (r_reg.state)
      fsic_pkg::FSIC_IDLE:
      begin
        if (sw_wr_i && sw_addr_i == `FSIC_REG_CMD)
        begin
          r_next.op   = fsic_pkg::fsic_op_type'(sw_wdata_i[1:0]);
          r_next.step = 2'd0;
          // Busy device would ignore these; refuse rather than leave a stale mode
          if ((r_next.op == fsic_pkg::FSIC_OP_ID || r_next.op == fsic_pkg::FSIC_OP_CLR)
              && !r_reg.rb_s2)
          begin
            r_next.refused = 1'b1;
          end
          else
          begin
            r_next.refused = 1'b0;
            r_next.busy    = 1'b1;
            if (r_next.op == fsic_pkg::FSIC_OP_ERASE)
            begin
              r_next.efail = 1'b0;
            end
            r_next.state   = fsic_pkg::FSIC_NEXT;
          end
        end
      end
      fsic_pkg::FSIC_NEXT:
      begin
        r_next.state = fsic_pkg::FSIC_WR_SETUP;
        r_next.pins.ce_n  = 1'b0;
        r_next.pins.dq_oe = 1'b1;
        r_next.pins.addr  = '0;
        case (r_reg.op)
          fsic_pkg::FSIC_OP_ID:
          begin
            if (r_reg.step == 2'd0)
            begin
              r_next.pins.dq_out = {8'h00, OPC_READ_ID};
            end
            else
            begin
              // Word offset goes out on A1 upward, A0 held low
              r_next.pins.addr = {r_reg.addr_reg[22:0], 1'b0};
            end
          end
          fsic_pkg::FSIC_OP_STAT:
          begin
            r_next.pins.dq_out = {8'h00, OPC_STATUS};
          end
          fsic_pkg::FSIC_OP_CLR:
          begin
            r_next.pins.dq_out = {8'h00, `FSIC_CLR_STATUS};
          end
          fsic_pkg::FSIC_OP_ERASE:
          begin
            // Both writes carry the same in-block address so no abort occurs
            r_next.pins.addr   = r_reg.addr_reg;
            r_next.pins.dq_out = {8'h00, (r_reg.step == 2'd0) ? OPC_SETUP : OPC_CONFIRM};
          end
          default: r_next.pins.dq_out = '0;
        endcase
        if ((r_reg.op == fsic_pkg::FSIC_OP_ERASE && r_reg.step == 2'd2) ||
            (r_reg.op != fsic_pkg::FSIC_OP_ERASE && r_reg.step == 2'd1 &&
             r_reg.op != fsic_pkg::FSIC_OP_CLR))
        begin
          r_next.pins.dq_oe = 1'b0;
          r_next.pins.oe_n  = 1'b0;
          r_next.cnt        = RD_CYC - 8'd1;
          r_next.state      = fsic_pkg::FSIC_RD_WAIT;
        end
        else if ((r_reg.op == fsic_pkg::FSIC_OP_CLR && r_reg.step == 2'd1) ||
                 r_reg.step == 2'd3 ||
                 (r_reg.op != fsic_pkg::FSIC_OP_ERASE && r_reg.step == 2'd2))
        begin
          r_next.pins  = RST_VAL.pins;
          r_next.busy  = 1'b0;
          r_next.state = fsic_pkg::FSIC_IDLE;
        end
      end
      fsic_pkg::FSIC_WR_SETUP:
      begin
        r_next.pins.we_n = 1'b0;
        r_next.cnt       = WP_CYC - 8'd1;
        r_next.state     = fsic_pkg::FSIC_WR_PULSE;
      end
      fsic_pkg::FSIC_WR_PULSE:
      begin
        if (r_reg.cnt == 8'd0)
        begin
          r_next.pins.we_n = 1'b1;
          r_next.state     = fsic_pkg::FSIC_WR_HOLD;
        end
        else
        begin
          r_next.cnt = r_reg.cnt - 8'd1;
        end
      end
      fsic_pkg::FSIC_WR_HOLD:
      begin
        r_next.pins.ce_n  = 1'b1;
        r_next.pins.dq_oe = 1'b0;
        r_next.step       = r_reg.step + 2'd1;
        r_next.state      = fsic_pkg::FSIC_GAP;
      end
      fsic_pkg::FSIC_RD_WAIT:
      begin
        if (r_reg.cnt == 8'd0)
        begin
          r_next.data_reg  = r_reg.dq_s2;
          // Deselect after every read so the next poll latches fresh status
          r_next.pins.oe_n = 1'b1;
          r_next.pins.ce_n = 1'b1;
          r_next.state     = fsic_pkg::FSIC_GAP;
          if (r_reg.op != fsic_pkg::FSIC_OP_ERASE)
          begin
            r_next.step = r_reg.step + 2'd1;
          end
          else if (r_reg.dq_s2[`FSIC_SR_READY] && r_reg.rb_s2)
          begin
            // Error flag only trusted once ready; held until the next erase command is accepted
            r_next.efail = r_reg.dq_s2[`FSIC_SR_ERASE_ERR];
            r_next.step  = 2'd3;
          end
        end
        else
        begin
          r_next.cnt = r_reg.cnt - 8'd1;
        end
      end
      fsic_pkg::FSIC_GAP:
      begin
        r_next.state = fsic_pkg::FSIC_NEXT;
      end
      default: r_next = RST_VAL;
    endcase
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      r_reg <= RST_VAL;
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  assign sw_rdata_o        = r_reg.rdata;
  assign flash_addr_o      = r_reg.pins.addr;
  assign flash_dq_o        = r_reg.pins.dq_out;
  assign flash_dq_oe_o     = r_reg.pins.dq_oe;
  assign chip_enable_0_n_o = r_reg.pins.ce_n;
  assign output_enable_n_o = r_reg.pins.oe_n;
  assign write_enable_n_o  = r_reg.pins.we_n;

endmodule

// *** sim/fsic_host_checker.sv ***
module fsic_host_checker (
  input wire logic        clock_i,
  input wire logic        rst_b_i,
  input wire logic [7:0]  sw_addr_i,
  input wire logic [31:0] sw_wdata_i,
  input wire logic        sw_wr_i,
  input wire logic        sw_rd_i,
  input wire logic [31:0] sw_rdata_o,
  input wire logic [23:0] flash_addr_o,
  input wire logic [15:0] flash_dq_i,
  input wire logic [15:0] flash_dq_o,
  input wire logic        flash_dq_oe_o,
  input wire logic        chip_enable_0_n_o,
  input wire logic        output_enable_n_o,
  input wire logic        write_enable_n_o,
  input wire logic        ready_busy_level_i
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  logic [7:0] wlen_reg;
  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i || write_enable_n_o)
      wlen_reg <= 8'h00;
    else
      wlen_reg <= wlen_reg + 8'h01;
  end
  sequence s_rd_pulse;
    ##39 !output_enable_n_o ##1 output_enable_n_o;
  endsequence
  sequence s_ce_gap;
    chip_enable_0_n_o [*2];
  endsequence
  wr_pulse_len_a: assert property ($rose(write_enable_n_o) |-> wlen_reg == 8'h12)
    else $error("write pulse length wrong");
  rd_pulse_len_a: assert property ($fell(output_enable_n_o) |-> s_rd_pulse)
    else $error("read pulse length wrong");
  ce_gap_a: assert property ($rose(chip_enable_0_n_o) |-> s_ce_gap)
    else $error("chip enable gap too short");
  we_in_ce_a: assert property (!write_enable_n_o |-> !chip_enable_0_n_o && output_enable_n_o)
    else $error("write strobe outside select");
  oe_in_ce_a: assert property (!output_enable_n_o |-> !chip_enable_0_n_o && !flash_dq_oe_o)
    else $error("read strobe with bus driven");
  cmd_stable_a: assert property (!write_enable_n_o |-> $stable(flash_dq_o) && flash_dq_oe_o)
    else $error("command data moved in write");
  rdata_idle_a: assert property (!$past(sw_rd_i) |-> sw_rdata_o == 32'h0)
    else $error("read data outside read slot");
  reset_pins_a: assert property (disable iff (1'b0) !rst_b_i |=> chip_enable_0_n_o &&
    output_enable_n_o && write_enable_n_o && !flash_dq_oe_o) else $error("pins active in reset");
endmodule

// *** sim/fsic_flash_model.sv ***
module fsic_flash_model #(
  parameter logic [7:0] MAKER_CODE  = 8'h42, // Arbitrary value
  parameter logic [7:0] DEVICE_CODE = 8'h37, // Arbitrary value
  parameter logic [7:0] LOCK_MAP    = 8'h02
) (
  input  wire logic [23:0] addr_i,
  input  wire logic [15:0] dq_i,
  input  wire logic        ce_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        we_n_i,
  input  wire logic        supply_low_i,
  input  wire logic        override_hv_i,
  output logic      [15:0] dq_o,
  output logic             ready_busy_level_o = 1'b1
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  sr_reg = 8'h80;
  logic [1:0]  mode_reg = 2'h0;
  logic        setup_reg = 1'b0;
  logic [15:0] rd_reg = 16'h0;
  always @(posedge we_n_i)
  begin
    if (!ce_n_i && setup_reg)
    begin
      setup_reg = 1'b0;
      mode_reg = 2'h2;
      if (dq_i[7:0] != 8'h04)
        sr_reg = sr_reg | 8'h30;
      else if (supply_low_i)
        sr_reg = sr_reg | 8'h28;
      else if (LOCK_MAP[addr_i[19:17]] && !override_hv_i)
        sr_reg = sr_reg | 8'h22;
      else
      begin
        sr_reg[7] = 1'b0;
        ready_busy_level_o = 1'b0;
        #2000;
        sr_reg[7] = 1'b1;
        ready_busy_level_o = 1'b1;
      end
    end
    else if (!ce_n_i)
      case (dq_i[7:0])
        8'h01: if (sr_reg[7]) mode_reg = 2'h1;
        8'h02: mode_reg = 2'h2;
        8'h03: setup_reg = 1'b1;
        8'h50: if (sr_reg[7]) sr_reg = sr_reg & 8'hc5;
        default: mode_reg = 2'h0;
      endcase
  end
  // Wait so both selects falling in one step are seen together
  always @(negedge oe_n_i or negedge ce_n_i)
  begin
    #1;
    if (!oe_n_i && !ce_n_i)
      case (mode_reg)
        2'h1: rd_reg = {8'h00, addr_i[2:1] == 2'h0 ? MAKER_CODE : addr_i[2:1] == 2'h1 ?
          DEVICE_CODE : {7'h00, addr_i[2:1] == 2'h2 && LOCK_MAP[addr_i[19:17]]}};
        2'h2: rd_reg = sr_reg[7] ? {8'h00, sr_reg} : 16'h0055;
        default: rd_reg = 16'hffff;
      endcase
  end
  // Released bus never repeats the last word
  assign dq_o = (!ce_n_i && !oe_n_i) ? rd_reg : ~rd_reg;
endmodule

// *** sim/tb_fsic_host.sv ***
module tb_fsic_host;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] MAKER = 8'h42; // Arbitrary value
  localparam logic [7:0] DEVICE = 8'h37; // Arbitrary value
  logic        clock_i = 1'b0, rst_b_i = 1'b0, sw_wr_i = 1'b0, sw_rd_i = 1'b0;
  logic [7:0]  sw_addr_i = 8'h00;
  logic [31:0] sw_wdata_i = 32'h0, sw_rdata_o, v;
  logic [23:0] flash_addr_o;
  logic [15:0] flash_dq_i, flash_dq_o;
  logic        flash_dq_oe_o, chip_enable_0_n_o, output_enable_n_o, write_enable_n_o;
  logic        ready_busy_level_i, supply_low = 1'b0, override_hv = 1'b0;
  int          n_fail = 0, checks_done = 0, cyc = 0;
  logic [23:0] ia [5] = '{24'h0, 24'h1, 24'h010002, 24'h2, 24'h3};
  logic [7:0]  idv [5] = '{MAKER, DEVICE, 8'h01, 8'h00, 8'h00};
  logic [23:0] ea [5] = '{24'h100, 24'h020000, 24'h100, 24'h020000, 24'h100};
  logic [7:0]  es [5] = '{8'h80, 8'ha2, 8'ha2, 8'h80, 8'ha8};
  logic [4:0]  el = 5'b10000, eh = 5'b01000;
  fsic_host fsic_host_inst (.*);
  fsic_flash_model #(.MAKER_CODE(MAKER), .DEVICE_CODE(DEVICE), .LOCK_MAP(8'h02))
    fsic_flash_model_inst (.addr_i(flash_addr_o), .dq_i(flash_dq_o), .ce_n_i(chip_enable_0_n_o),
    .oe_n_i(output_enable_n_o), .we_n_i(write_enable_n_o), .supply_low_i(supply_low),
    .override_hv_i(override_hv), .dq_o(flash_dq_i), .ready_busy_level_o(ready_busy_level_i));
  always #2 clock_i = ~clock_i;
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    {sw_addr_i, sw_wdata_i, sw_wr_i} <= {a, d, 1'b1};
    @(posedge clock_i);
    sw_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clock_i);
    {sw_addr_i, sw_rd_i} <= {a, 1'b1};
    @(posedge clock_i);
    sw_rd_i <= 1'b0;
    #1 v = sw_rdata_o;
  endtask
  task automatic op(input logic [1:0] c, input logic [23:0] a);
    wr(8'h04, {8'h00, a});
    wr(8'h00, {30'h0, c});
    repeat (2) @(posedge clock_i);
    for (int k = 0; k < 2000; k++)
    begin
      rd(8'h08);
      if (v[0] === 1'b0) break;
    end
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Successful erases take about 600 cycles each; ceiling leaves wide margin
  always @(posedge clock_i)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      n_fail++;
      end_of_test;
    end
  end
  initial
  begin
    repeat (4) @(posedge clock_i);
    rst_b_i <= 1'b1;
    // Ready level not yet through the synchroniser, so the id command is refused
    wr(8'h00, 32'h0);
    rd(8'h08);
    chk("refused", 32'ha, v);
    rd(8'h10);
    chk("unmapped", 32'h0, v);
    for (int i = 0; i < 5; i++)
    begin
      op(2'd0, ia[i]);
      rd(8'h0c);
      chk("id", {24'h0, idv[i]}, v);
    end
    rd(8'h08);
    chk("stat", 32'h8, v);
    for (int i = 0; i < 5; i++)
    begin
      {supply_low, override_hv} <= {el[i], eh[i]};
      op(2'd3, ea[i]);
      chk("efail", {31'h0, es[i][5]}, {31'h0, v[2]});
      chk("ready", 32'h8, v & 32'h9);
      rd(8'h0c);
      chk("status", {24'h0, es[i]}, v);
      if (i == 2 || i == 4)
      begin
        op(2'd2, 24'h0);
        op(2'd1, 24'h0);
        rd(8'h0c);
        chk("cleared", 32'h80, v);
      end
    end
    end_of_test;
  end
endmodule
bind fsic_host fsic_host_checker fsic_host_checker_inst (.*);
